/* File: include/sclc_pkg.sv */
// constants, types and the checksum helper for the sensor command block
// assumes a 50 MHz system clock and an i2c link sampled by that clock
// Notes on behaviour
// - self-calibration is enabled after reset until a host command changes it
// - the setting is volatile only; saving it needs a separate command
// - 0x2416 plus word and crc sets (1) or clears (0) calibration, no reply
// - 0x2313 replies with calibration state word plus crc within 1 ms
// - low-power mode makes a new result about every 30 seconds
// - 0x21ac starts low-power mode, takes no parameter and gives no reply
// - results are read in low-power mode the same way as normal mode
// - reading a result before it is ready gets a nack
// - 0xe4b8 replies with a word whose low 11 bits are nonzero when ready
// - each data word goes msb first and is followed by an 8-bit crc; command words carry no crc
package sclc_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h40; // bus address, value arbitrary
    localparam logic [15:0] CMD_SET_CAL = 16'h2416;
    localparam logic [15:0] CMD_GET_CAL = 16'h2313;
    localparam logic [15:0] CMD_START_LP = 16'h21ac;
    localparam logic [15:0] CMD_GET_RDY = 16'he4b8;
    localparam logic [15:0] CMD_READ_MEAS = 16'h3c05;
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [2:0] NB_CMD = 3'h2;
    localparam logic [2:0] NB_PARAM = 3'h5;
    localparam logic [2:0] NB_SAT = 3'h7;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam int CLK_HZ = 50_000_000;
    localparam int EXEC_US = 1000;
    localparam int EXEC_CYC = CLK_HZ / 1_000_000 * EXEC_US;
    localparam int LP_PERIOD_S = 30;
    localparam longint LP_CYC = longint'(CLK_HZ) * LP_PERIOD_S;
    localparam logic [7:0] REG_STAT = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h08;
    localparam logic [7:0] REG_MEAS = 8'h0c;
    localparam int EV_RDY = 0;
    localparam int EV_CAL = 1;
    localparam int EV_CRC = 2;
    localparam int EV_LP = 3;
    localparam int ST_CAL = 0;
    localparam int ST_LP = 1;
    localparam int ST_RDY = 2;
    localparam int ST_BUSY = 3;
    localparam logic CAL_RST = 1'b1;
    localparam logic [15:0] MEAS_RST = 16'h0000;

    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WRX, I_WACK, I_TX, I_RACK, I_IGN} sclc_i2c_st_t;
    typedef enum logic [1:0] {RSP_NONE, RSP_CAL, RSP_RDY, RSP_MEAS} sclc_rsp_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        sclc_i2c_st_t st;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic rw;
        logic [39:0] wbuf;
        logic [2:0] nb;
        logic hnack;
        logic sda_oe;
        logic sdo;
        sclc_rsp_t pend;
        logic [23:0] resp;
        logic [1:0] txi;
        logic auto_self_calibration;
        logic lp;
        logic rdy;
        logic [15:0] busy;
        logic [31:0] lpcnt;
        logic [15:0] meas;
        logic [3:0] stat;
        logic [3:0] mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sclc_state_t;

    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8
endpackage : sclc_pkg

/* File: rtl/sclc_cmd.sv */
// i2c command interpreter for calibration, low-power mode and data-ready
// assumes open-drain sda resolved outside; scl/sda are async to mclk_i
`timescale 1ns/10ps
module sclc_cmd #(
    parameter logic [15:0] EXEC_CYC = 16'(sclc_pkg::EXEC_CYC),
    parameter logic [31:0] LP_CYC = 32'(sclc_pkg::LP_CYC)
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o
);
    sclc_pkg::sclc_state_t q;
    sclc_pkg::sclc_state_t d;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic ack_rd;
    logic set_ok;
    logic crc_bad;
    logic lp_go;
    logic acc;
    logic wr;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [15:0] cmd;
    logic [15:0] w;
    logic [7:0] txb;

    always_comb begin
        d = q;
        ack_rd = 1'b0;
        set_ok = 1'b0;
        crc_bad = 1'b0;
        lp_go = 1'b0;
        ev = 4'h0;
        clr = 4'h0;
        cmd = 16'h0000;
        // three stages; a level counts once stages two and three agree
        d.scl_s = {q.scl_s[1:0], scl_i};
        d.sda_s = {q.sda_s[1:0], sda_i};
        if (q.scl_s[1] == q.scl_s[2]) begin
            d.scl_f = q.scl_s[2];
        end
        if (q.sda_s[1] == q.sda_s[2]) begin
            d.sda_f = q.sda_s[2];
        end
        rise = d.scl_f & ~q.scl_f;
        fall = ~d.scl_f & q.scl_f;
        start = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f;
        stop = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f;
        unique case (q.pend)
            sclc_pkg::RSP_CAL: w = {15'h0000, q.auto_self_calibration};
            sclc_pkg::RSP_RDY: w = {15'h0000, q.rdy};
            sclc_pkg::RSP_MEAS: w = q.meas;
            sclc_pkg::RSP_NONE: w = 16'h0000;
        endcase
        unique case (q.txi)
            2'h0: txb = q.resp[23:16];
            2'h1: txb = q.resp[15:8];
            2'h2: txb = q.resp[7:0];
            2'h3: txb = 8'hff;
        endcase
        if (q.busy != 16'h0000) begin
            d.busy = q.busy - 16'h0001;
        end

        // a write frame is acted on when it ends, by stop or repeated start
        if ((start || stop) && q.st != sclc_pkg::I_IDLE && !q.rw) begin
            cmd = (q.nb == sclc_pkg::NB_PARAM) ? q.wbuf[39:24] : q.wbuf[15:0];
            if (q.nb == sclc_pkg::NB_CMD) begin
                if (cmd == sclc_pkg::CMD_GET_CAL) begin
                    d.pend = sclc_pkg::RSP_CAL;
                    d.busy = EXEC_CYC;
                end else if (cmd == sclc_pkg::CMD_GET_RDY) begin
                    d.pend = sclc_pkg::RSP_RDY;
                    d.busy = EXEC_CYC;
                end else if (cmd == sclc_pkg::CMD_READ_MEAS) begin
                    d.pend = sclc_pkg::RSP_MEAS;
                end else if (cmd == sclc_pkg::CMD_START_LP) begin
                    d.pend = sclc_pkg::RSP_NONE;
                    lp_go = 1'b1;
                end
            end else if (q.nb == sclc_pkg::NB_PARAM && cmd == sclc_pkg::CMD_SET_CAL) begin
                d.pend = sclc_pkg::RSP_NONE;
                d.busy = EXEC_CYC;
                if (sclc_pkg::crc8(q.wbuf[23:8]) != q.wbuf[7:0]) begin
                    crc_bad = 1'b1;
                end else if (q.wbuf[23:9] == 15'h0000) begin
                    set_ok = 1'b1;
                    // volatile only, lost on reset
                    d.auto_self_calibration = q.wbuf[8];
                end
            end
        end

        if (start) begin
            d.st = sclc_pkg::I_ADDR;
            d.bitc = 4'h0;
            d.nb = 3'h0;
            d.rw = 1'b0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.st = sclc_pkg::I_IDLE;
            d.rw = 1'b0;
            d.sda_oe = 1'b0;
        end else if (rise) begin
            unique case (q.st)
                sclc_pkg::I_ADDR, sclc_pkg::I_WRX: begin
                    d.sh = {q.sh[6:0], d.sda_f};
                    d.bitc = q.bitc + 4'h1;
                end
                sclc_pkg::I_TX: d.bitc = q.bitc + 4'h1;
                sclc_pkg::I_RACK: d.hnack = d.sda_f;
                default: ;
            endcase
        end else if (fall) begin
            unique case (q.st)
                sclc_pkg::I_ADDR: begin
                    if (q.bitc == sclc_pkg::BITS_BYTE) begin
                        // busy, nothing to say, or result not yet ready: nack
                        if (q.sh[7:1] == sclc_pkg::DEV_ADDR && q.busy == 16'h0000
                            && (!q.sh[0] || (q.pend != sclc_pkg::RSP_NONE
                            && (q.pend != sclc_pkg::RSP_MEAS || q.rdy)))) begin
                            d.st = sclc_pkg::I_AACK;
                            d.sda_oe = 1'b1;
                            d.rw = q.sh[0];
                            if (q.sh[0]) begin
                                ack_rd = 1'b1;
                                d.txi = 2'h0;
                                d.resp = {w, sclc_pkg::crc8(w)};
                                if (q.pend == sclc_pkg::RSP_MEAS) begin
                                    d.rdy = 1'b0;
                                end
                            end
                        end else begin
                            d.st = sclc_pkg::I_IGN;
                        end
                    end
                end
                sclc_pkg::I_WRX: begin
                    if (q.bitc == sclc_pkg::BITS_BYTE) begin
                        d.st = sclc_pkg::I_WACK;
                        d.sda_oe = 1'b1;
                        d.wbuf = {q.wbuf[31:0], q.sh};
                        d.nb = (q.nb == sclc_pkg::NB_SAT) ? q.nb : q.nb + 3'h1;
                    end
                end
                sclc_pkg::I_AACK, sclc_pkg::I_WACK, sclc_pkg::I_RACK: begin
                    d.bitc = 4'h0;
                    if (q.st == sclc_pkg::I_RACK && q.hnack) begin
                        d.st = sclc_pkg::I_IGN;
                        d.sda_oe = 1'b0;
                    end else if (q.rw) begin
                        d.st = sclc_pkg::I_TX;
                        d.sh = txb;
                        d.sda_oe = ~txb[7];
                        d.txi = (q.txi == 2'h3) ? q.txi : q.txi + 2'h1;
                    end else begin
                        d.st = sclc_pkg::I_WRX;
                        d.sda_oe = 1'b0;
                    end
                end
                sclc_pkg::I_TX: begin
                    if (q.bitc == sclc_pkg::BITS_BYTE) begin
                        d.st = sclc_pkg::I_RACK;
                        d.sda_oe = 1'b0;
                    end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oe = ~q.sh[6];
                    end
                end
                default: ;
            endcase
        end

        // result timer runs after the read path so a new result wins
        if (lp_go) begin
            d.lp = 1'b1;
            d.lpcnt = LP_CYC - 32'h1;
        end else if (q.lp) begin
            if (q.lpcnt == 32'h0) begin
                d.rdy = 1'b1;
                d.lpcnt = LP_CYC - 32'h1;
            end else begin
                d.lpcnt = q.lpcnt - 32'h1;
            end
        end
        ev[sclc_pkg::EV_RDY] = q.lp && !lp_go && q.lpcnt == 32'h0;
        ev[sclc_pkg::EV_CAL] = set_ok;
        ev[sclc_pkg::EV_CRC] = crc_bad;
        ev[sclc_pkg::EV_LP] = lp_go;

        // apb: answer one cycle into the access phase, act when pready seen
        acc = psel_i & penable_i & ~q.pready;
        wr = psel_i & penable_i & q.pready & pwrite_i;
        d.pready = acc;
        d.prdata = 32'h0;
        d.pslverr = 1'b0;
        if (acc) begin
            unique case (paddr_i)
                sclc_pkg::REG_STAT: d.prdata[3:0] = pwrite_i ? 4'h0 : q.stat;
                sclc_pkg::REG_MASK: d.prdata[3:0] = pwrite_i ? 4'h0 : q.mask;
                sclc_pkg::REG_STATE: begin
                    if (!pwrite_i) begin
                        d.prdata[sclc_pkg::ST_CAL] = q.auto_self_calibration;
                        d.prdata[sclc_pkg::ST_LP] = q.lp;
                        d.prdata[sclc_pkg::ST_RDY] = q.rdy;
                        d.prdata[sclc_pkg::ST_BUSY] = q.busy != 16'h0000;
                    end
                end
                sclc_pkg::REG_MEAS: d.prdata[15:0] = pwrite_i ? 16'h0000 : q.meas;
                default: d.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr_i)
                sclc_pkg::REG_STAT: clr = pwdata_i[3:0];
                sclc_pkg::REG_MASK: d.mask = pwdata_i[3:0];
                sclc_pkg::REG_MEAS: d.meas = pwdata_i[15:0];
                default: ;
            endcase
        end
        // an event in the clearing cycle survives
        d.stat = (q.stat & ~clr) | ev;
        d.irq = |(d.stat & d.mask);
        d.sdo = 1'b0;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            q.st <= sclc_pkg::I_IDLE;
            q.pend <= sclc_pkg::RSP_NONE;
            q.meas <= sclc_pkg::MEAS_RST;
            q.auto_self_calibration <= sclc_pkg::CAL_RST;
        end else begin
            q <= d;
        end
    end

    assign sda_o = q.sdo;
    assign sda_oe_o = q.sda_oe;
    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign irq_o = q.irq;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    property p_cal_hold;
        !set_ok |=> $stable(q.auto_self_calibration);
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("calibration changed without command");

    property p_cal_set;
        set_ok |=> q.auto_self_calibration == $past(q.wbuf[8]) && q.stat[sclc_pkg::EV_CAL];
    endproperty
    a_cal_set: assert property (p_cal_set) else $error("set command not applied");

    property p_crc_drop;
        crc_bad |=> $stable(q.auto_self_calibration) && q.stat[sclc_pkg::EV_CRC];
    endproperty
    a_crc_drop: assert property (p_crc_drop) else $error("bad crc parameter applied");

    property p_get_cal;
        ack_rd && q.pend == sclc_pkg::RSP_CAL |=> q.resp[23:8] == {15'h0000, $past(q.auto_self_calibration)};
    endproperty
    a_get_cal: assert property (p_get_cal) else $error("calibration reply wrong");

    property p_rdy_word;
        ack_rd && q.pend == sclc_pkg::RSP_RDY |=> (q.resp[18:8] != 11'h000) == $past(q.rdy);
    endproperty
    a_rdy_word: assert property (p_rdy_word) else $error("data-ready reply wrong");

    property p_crc_tx;
        $past(ack_rd) |-> q.resp[7:0] == sclc_pkg::crc8(q.resp[23:8]);
    endproperty
    a_crc_tx: assert property (p_crc_tx) else $error("reply crc wrong");

    property p_lp_tick;
        q.lp && !lp_go && q.lpcnt == 32'h0 |=> q.rdy && q.stat[sclc_pkg::EV_RDY];
    endproperty
    a_lp_tick: assert property (p_lp_tick) else $error("periodic result missing");

    property p_lp_start;
        lp_go |=> q.lp ##1 q.lpcnt == LP_CYC - 32'h2;
    endproperty
    a_lp_start: assert property (p_lp_start) else $error("low-power start failed");

    property p_nack_meas;
        fall && !start && !stop && q.st == sclc_pkg::I_ADDR && q.bitc == sclc_pkg::BITS_BYTE && q.sh[0]
            && q.pend == sclc_pkg::RSP_MEAS && !q.rdy |=> q.st == sclc_pkg::I_IGN && !q.sda_oe;
    endproperty
    a_nack_meas: assert property (p_nack_meas) else $error("unready result was acked");

    property p_meas_read;
        ack_rd && q.pend == sclc_pkg::RSP_MEAS |=> q.resp[23:8] == $past(q.meas);
    endproperty
    a_meas_read: assert property (p_meas_read) else $error("result reply wrong");

    c_set: cover property (set_ok);
    c_meas: cover property (ack_rd && q.pend == sclc_pkg::RSP_MEAS);
    c_crc: cover property (crc_bad);
    c_irq: cover property ($rose(q.irq));
endmodule : sclc_cmd

/* File: sim/sclc_cmd_tb.sv */
// self-checking bench for the sensor command block over i2c and apb
// assumes sclc_pkg and the host model are compiled first
`timescale 1ns/10ps
module sclc_cmd_tb;
    localparam logic [15:0] EXEC = 16'd200;
    localparam logic [31:0] LP = 32'd4000;
    logic mclk_i, arst_n_i, psel_i, penable_i, pwrite_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, pslverr_o, irq_o, sda_o, sda_oe_o, scl, host_low;
    wire sda_w = !(host_low || sda_oe_o);
    logic [32:0] exp_q[$];
    logic [32:0] obs_v;
    event obs_ev;
    int bad_count = 0;
    int checks = 0;
    int seed = 32'h3bfe;
    logic [15:0] m;

    sclc_cmd #(.EXEC_CYC(EXEC), .LP_CYC(LP)) u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));
    sclc_i2c_host u_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_w));

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic post(input logic [32:0] v);
        obs_v = v;
        -> obs_ev;
    endtask : post

    // results on the link and the irq pin are posted, apb reads are watched
    always @(obs_ev) check(obs_v, exp_q.pop_front());
    // read data taken at the rising edge where pready is seen high
    always @(posedge mclk_i) begin
        if (psel_i === 1'b1 && penable_i === 1'b1 && pready_o === 1'b1 && pwrite_i === 1'b0) begin
            check({pslverr_o, prdata_o}, exp_q.pop_front());
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        // no cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic irq_is(input logic v);
        exp_q.push_back(33'(v));
        repeat (2) @(negedge mclk_i);
        post(33'(irq_o));
    endtask : irq_is

    task automatic exec_wait();
        repeat (EXEC + 16'd8) @(posedge mclk_i);
    endtask : exec_wait

    task automatic send(input logic [15:0] c, input logic hasp, input logic [23:0] p);
        logic a;
        // host moves on falling edges, off the device's sampling edge
        @(negedge mclk_i);
        u_host.start();
        u_host.wbyte({sclc_pkg::DEV_ADDR, 1'b0}, a);
        u_host.wbyte(c[15:8], a);
        u_host.wbyte(c[7:0], a);
        if (hasp) for (int i = 2; i >= 0; i--) u_host.wbyte(p[8*i +: 8], a);
        u_host.stop();
    endtask : send

    task automatic fetch(input logic ok, input logic [23:0] r);
        logic a;
        logic [7:0] b;
        exp_q.push_back(33'(!ok));
        @(negedge mclk_i);
        u_host.start();
        u_host.wbyte({sclc_pkg::DEV_ADDR, 1'b1}, a);
        post(33'(a));
        for (int i = 2; i >= 0 && ok && !a; i--) begin
            exp_q.push_back(33'(r[8*i +: 8]));
            u_host.rbyte(i == 0, b);
            post(33'(b));
        end
        u_host.stop();
    endtask : fetch

    function automatic logic [7:0] crc(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction : crc

    initial begin
        #(20 * 40000);
        bad_count++;
        test_done();
    end

    initial begin
        arst_n_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        repeat (8) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rd(sclc_pkg::REG_STATE, 33'h1);
        rd(sclc_pkg::REG_MASK, 33'h0);
        rd(sclc_pkg::REG_STAT, 33'h0);
        rd(8'h10, {1'b1, 32'h0});
        $display("test reset done");
        send(sclc_pkg::CMD_GET_CAL, 1'b0, 24'h0);
        fetch(1'b0, 24'h0);
        exec_wait();
        fetch(1'b1, 24'h0001b0);
        fetch(1'b1, 24'h0001b0);
        $display("test get calibration done");
        send(sclc_pkg::CMD_SET_CAL, 1'b1, 24'h000081);
        exec_wait();
        rd(sclc_pkg::REG_STATE, 33'h0);
        send(sclc_pkg::CMD_SET_CAL, 1'b1, 24'h0001b1);
        exec_wait();
        rd(sclc_pkg::REG_STATE, 33'h0);
        rd(sclc_pkg::REG_STAT, 33'h6);
        send(sclc_pkg::CMD_GET_CAL, 1'b0, 24'h0);
        exec_wait();
        fetch(1'b1, 24'h000081);
        $display("test set calibration done");
        irq_is(1'b0);
        apb(1'b1, sclc_pkg::REG_MASK, 32'h4);
        irq_is(1'b1);
        apb(1'b1, sclc_pkg::REG_STAT, 32'hf);
        irq_is(1'b0);
        rd(sclc_pkg::REG_STAT, 33'h0);
        send(sclc_pkg::CMD_SET_CAL, 1'b1, 24'h0001b0);
        exec_wait();
        rd(sclc_pkg::REG_STATE, 33'h1);
        $display("test interrupt done");
        send(sclc_pkg::CMD_SET_CAL, 1'b1, 24'h000081);
        exec_wait();
        rd(sclc_pkg::REG_STATE, 33'h0);
        // setting is volatile: a reset brings calibration back on
        arst_n_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rd(sclc_pkg::REG_STATE, 33'h1);
        rd(sclc_pkg::REG_STAT, 33'h0);
        $display("test reset volatile done");
        send(sclc_pkg::CMD_GET_RDY, 1'b0, 24'h0);
        exec_wait();
        fetch(1'b1, 24'h000081);
        send(sclc_pkg::CMD_READ_MEAS, 1'b0, 24'h0);
        fetch(1'b0, 24'h0);
        $display("test not ready done");
        m = 16'($random(seed));
        apb(1'b1, sclc_pkg::REG_MEAS, {16'h0, m});
        send(sclc_pkg::CMD_START_LP, 1'b0, 24'h0);
        rd(sclc_pkg::REG_STATE, 33'h3);
        send(sclc_pkg::CMD_GET_RDY, 1'b0, 24'h0);
        exec_wait();
        fetch(1'b1, 24'h000081);
        repeat (LP) @(posedge mclk_i);
        send(sclc_pkg::CMD_GET_RDY, 1'b0, 24'h0);
        exec_wait();
        fetch(1'b1, 24'h0001b0);
        rd(sclc_pkg::REG_STAT, 33'h9);
        send(sclc_pkg::CMD_READ_MEAS, 1'b0, 24'h0);
        fetch(1'b1, {m, crc(m)});
        fetch(1'b0, 24'h0);
        // open drain: the data output never drives high
        exp_q.push_back(33'h0);
        post(33'(sda_o));
        $display("test low power done");
        test_done();
    end
endmodule : sclc_cmd_tb

/* File: sim/sclc_i2c_host.sv */
// i2c host model for the sensor command block: drives scl, pulls sda low
// assumes the bench resolves sda with a pull-up from both pull-downs
`timescale 1ns/10ps
module sclc_i2c_host (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    // scl stands high between frames; one bit slot is 160 ns
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic slot(input logic b, output logic s);
        sda_low_o = !b;
        #40;
        scl_o = 1'b1;
        #60;
        s = sda_i; // sampled late in the high phase, away from device edges
        #20;
        scl_o = 1'b0;
        #40;
    endtask : slot

    task automatic start();
        sda_low_o = 1'b0;
        #40;
        scl_o = 1'b1;
        #40;
        sda_low_o = 1'b1;
        #40;
        scl_o = 1'b0;
        #40;
    endtask : start

    task automatic stop();
        sda_low_o = 1'b1;
        #40;
        scl_o = 1'b1;
        #40;
        sda_low_o = 1'b0;
        #80;
    endtask : stop

    task automatic wbyte(input logic [7:0] b, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(b[i], s);
        slot(1'b1, nack);
    endtask : wbyte

    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, s);
            b[i] = s;
        end
        slot(last, s); // nack on the last byte ends the reply
    endtask : rbyte
endmodule : sclc_i2c_host
